// ### include/dsv_pkg.sv
// Constants and types shared by the test and view command handler
package dsv_pkg;
    // Command codes from the command parser
    typedef enum logic [1:0] {
        DSV_CMD_DSR  = 2'h0,
        DSV_CMD_TEST = 2'h1,
        DSV_CMD_VIEW = 2'h2
    } dsv_cmd_t;
    // Diagnostic test states, Gray ordered along the usual path
    typedef enum logic [2:0] {
        DSV_T_IDLE  = 3'h0,
        DSV_T_LOC   = 3'h1,
        DSV_T_LDATA = 3'h3,
        DSV_T_REM   = 3'h2,
        DSV_T_REMST = 3'h6,
        DSV_T_LOCST = 3'h7
    } dsv_test_t;
    // Largest accepted arguments
    localparam logic [3:0] DSV_DSR_ARG_MAX  = 4'h1;
    localparam logic [3:0] DSV_TEST_ARG_MAX = 4'h8;
    // Interface option register
    localparam int         DSV_IOR_DSR_BIT  = 6;
    localparam logic [7:0] DSV_IOR_RESET    = 8'h00;
    // Test option register fields
    localparam int         DSV_TOR_LOC_BIT   = 0;
    localparam int         DSV_TOR_LDATA_BIT = 2;
    localparam int         DSV_TOR_REM_BIT   = 3;
    localparam int         DSV_TOR_ST_BIT    = 4;
    localparam int         DSV_TOR_DENY_BIT  = 5;
    localparam int         DSV_TOR_RUN_BIT   = 6;
    localparam logic [7:0] DSV_TOR_RESET     = 8'h00;
    // Test timer: one register step is one second
    localparam longint     DSV_CLK_HZ        = 125000000;
    localparam longint     DSV_TIMER_UNIT_S  = 1;
    localparam int         DSV_SECOND_CYCLES = int'(DSV_TIMER_UNIT_S * DSV_CLK_HZ);
    // Configuration view report: six register words, then four number slots
    localparam logic [3:0] DSV_VIEW_PHONE0   = 4'h6;
    localparam logic [3:0] DSV_VIEW_LAST     = 4'h9;
endpackage

// ### logic/dsv_command_handler.sv
// Option, diagnostic test and configuration view command handler
// Notes on behaviour
// - Option argument 0 or none keeps data-set-ready on at all times except during self-test.
// - Option argument 1 makes data-set-ready follow the standard interface level.
// - The chosen option lands in interface option register bit 6.
// - Any running self-test forces data-set-ready off.
// - Test argument 0 or none ends the running test.
// - Test arguments 1 and 2 both start local loopback.
// - Test argument 3 starts local data loopback.
// - Test argument 4 allows remote loopback requests; default after reset.
// - Test argument 5 refuses remote loopback requests.
// - Test argument 6 starts remote loopback.
// - Test argument 7 starts remote loopback with self-test.
// - Test argument 8 starts local loopback with self-test.
// - Test option register bits 0 and 2 to 6 follow each accepted test command.
// - Every test argument from 0 to 8 is accepted and carried out.
// - A nonzero test timer ends locally started tests once it elapses.
// - View takes no argument and reports the active settings.
// - View also reports both stored profiles, 0 and 1.
// - View also lists the lengths of all four stored telephone numbers.
`timescale 1ns/100ps
`default_nettype none
module dsv_command_handler #(
    parameter int SECOND_CYCLES = dsv_pkg::DSV_SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Parsed command, one-cycle strobe
    input  wire logic                cmdValid,
    input  wire dsv_pkg::dsv_cmd_t   cmdCode,
    input  wire logic                cmdArgPresent,
    input  wire logic [3:0]          cmdArg,
    // Command result pulses
    output logic                     cmdOk,
    output logic                     cmdError,
    // Data-set-ready circuit
    input  wire logic                dsrStdLevel,
    output logic                     dsrOut,
    // Test timer register value, seconds, zero disables
    input  wire logic [7:0]          testTimer,
    // Option registers and test status
    output logic [7:0]               interfaceOptionReg,
    output logic [7:0]               testOptionReg,
    output dsv_pkg::dsv_test_t       testState,
    output logic                     remoteLbAllow,
    // Stored profiles and telephone number lengths
    input  wire logic [7:0]          profIor [2],
    input  wire logic [7:0]          profTor [2],
    input  wire logic [4:0]          phoneLen [4],
    // View report stream
    output logic                     viewValid,
    input  wire logic                viewReady,
    output logic [3:0]               viewIndex,
    output logic [7:0]               viewData
);
    import dsv_pkg::*;

    logic        dsrAccept;
    logic        testAccept;
    logic        viewAccept;
    logic        cmdBad;
    logic        viewBusy;
    logic        selfTestOn;
    logic        localTest;
    logic        timerExpire;
    logic [31:0] tickCount;
    logic [7:0]  secCount;
    logic [7:0]  next_viewData;
    dsv_test_t   next_testState;

    // Argument, absent or present, that a command carries
    function automatic logic [3:0] argOf(input logic present, input logic [3:0] arg);
        argOf = present ? arg : 4'h0;
    endfunction

    // Test option bits that a running state shows
    function automatic logic [7:0] torOf(input dsv_test_t st, input logic deny);
        logic [7:0] r;
        r = 8'h00;
        r[DSV_TOR_DENY_BIT] = deny;
        r[DSV_TOR_RUN_BIT] = (st != DSV_T_IDLE);
        r[DSV_TOR_LOC_BIT] = (st == DSV_T_LOC) || (st == DSV_T_LOCST);
        r[DSV_TOR_LDATA_BIT] = (st == DSV_T_LDATA);
        r[DSV_TOR_REM_BIT] = (st == DSV_T_REM) || (st == DSV_T_REMST);
        r[DSV_TOR_ST_BIT] = (st == DSV_T_REMST) || (st == DSV_T_LOCST);
        torOf = r;
    endfunction

    // A view is refused while an earlier report still streams
    assign dsrAccept = cmdValid && cmdCode == DSV_CMD_DSR
                       && argOf(cmdArgPresent, cmdArg) <= DSV_DSR_ARG_MAX;
    assign testAccept = cmdValid && cmdCode == DSV_CMD_TEST
                        && argOf(cmdArgPresent, cmdArg) <= DSV_TEST_ARG_MAX;
    assign viewAccept = cmdValid && cmdCode == DSV_CMD_VIEW
                        && !cmdArgPresent && !viewBusy;
    assign cmdBad = cmdValid && !(dsrAccept || testAccept || viewAccept);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmdOk <= 1'b0;
            cmdError <= 1'b0;
        end else begin
            cmdOk <= dsrAccept || testAccept || viewAccept;
            cmdError <= cmdBad;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interfaceOptionReg <= DSV_IOR_RESET;
        end else if (dsrAccept) begin
            interfaceOptionReg[DSV_IOR_DSR_BIT] <= argOf(cmdArgPresent, cmdArg) == 4'h1;
        end
    end

    assign selfTestOn = testState == DSV_T_REMST || testState == DSV_T_LOCST;

    // Registered so the pin never glitches on a state decode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dsrOut <= 1'b1;
        end else if (selfTestOn) begin
            dsrOut <= 1'b0;
        end else if (interfaceOptionReg[DSV_IOR_DSR_BIT]) begin
            dsrOut <= dsrStdLevel;
        end else begin
            dsrOut <= 1'b1;
        end
    end

    // Every test held here was started from the local terminal; far-end requests never land here
    assign localTest = testState != DSV_T_IDLE;
    assign timerExpire = localTest && testTimer != 8'h00
                         && secCount >= testTimer;

    always_ff @(posedge clk_sys) begin
        if (rst || !localTest || testAccept) begin
            tickCount <= 32'h0;
            secCount <= 8'h00;
        end else if (tickCount == 32'(SECOND_CYCLES - 1)) begin
            tickCount <= 32'h0;
            secCount <= secCount + 8'h01;
        end else begin
            tickCount <= tickCount + 32'h1;
        end
    end

    // Commands only reach here in command mode, so an escape already preceded a stop
    always_comb begin
        next_testState = testState;
        if (testAccept) begin
            unique case (argOf(cmdArgPresent, cmdArg))
                4'h0:    next_testState = DSV_T_IDLE;
                4'h1,
                4'h2:    next_testState = DSV_T_LOC;
                4'h3:    next_testState = DSV_T_LDATA;
                4'h6:    next_testState = DSV_T_REM;
                4'h7:    next_testState = DSV_T_REMST;
                4'h8:    next_testState = DSV_T_LOCST;
                default: next_testState = testState;
            endcase
        end else if (timerExpire) begin
            next_testState = DSV_T_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            testState <= DSV_T_IDLE;
        end else begin
            testState <= next_testState;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            remoteLbAllow <= 1'b1;
        end else if (testAccept && argOf(cmdArgPresent, cmdArg) == 4'h4) begin
            remoteLbAllow <= 1'b1;
        end else if (testAccept && argOf(cmdArgPresent, cmdArg) == 4'h5) begin
            remoteLbAllow <= 1'b0;
        end
    end

    // Mirrors state and permission; bit 1 and bit 7 stay clear
    assign testOptionReg = torOf(testState, !remoteLbAllow);

    // Word that the report moves to once the one on show is taken
    logic [3:0] nextIdx;
    assign nextIdx = viewIndex + 4'h1;

    // View report: active, profile 0, profile 1, then four number slots
    always_comb begin
        unique case (nextIdx)
            4'h1:    next_viewData = testOptionReg;
            4'h2:    next_viewData = profIor[0];
            4'h3:    next_viewData = profTor[0];
            4'h4:    next_viewData = profIor[1];
            4'h5:    next_viewData = profTor[1];
            // Words past the profiles carry one number length per slot
            4'h6,
            4'h7,
            4'h8,
            4'h9:    next_viewData = {3'h0, phoneLen[2'(nextIdx - DSV_VIEW_PHONE0)]};
            default: next_viewData = interfaceOptionReg;
        endcase
    end

    // Each word loads as the one before is taken, so it stands while the terminal stalls
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            viewBusy <= 1'b0;
            viewIndex <= 4'h0;
            viewData <= 8'h00;
        end else if (viewAccept) begin
            viewBusy <= 1'b1;
            viewIndex <= 4'h0;
            viewData <= interfaceOptionReg;
        end else if (viewBusy && viewReady) begin
            if (viewIndex == DSV_VIEW_LAST) begin
                viewBusy <= 1'b0;
            end else begin
                viewIndex <= nextIdx;
                viewData <= next_viewData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            viewValid <= 1'b0;
        end else begin
            viewValid <= viewAccept || (viewBusy && !(viewReady && viewIndex == DSV_VIEW_LAST));
        end
    end

    // Assertions
    sequence s_testCmd(logic [3:0] a);
        testAccept && argOf(cmdArgPresent, cmdArg) == a;
    endsequence

    a_dsr_forced_off: assert property (@(posedge clk_sys) disable iff (rst)
        selfTestOn |=> !dsrOut) else $error("dsr on during self-test");
    a_dsr_hold_on: assert property (@(posedge clk_sys) disable iff (rst)
        !selfTestOn && !interfaceOptionReg[DSV_IOR_DSR_BIT] |=> dsrOut)
        else $error("dsr not held on");
    a_dsr_follows_std: assert property (@(posedge clk_sys) disable iff (rst)
        !selfTestOn && interfaceOptionReg[DSV_IOR_DSR_BIT] |=> dsrOut == $past(dsrStdLevel))
        else $error("dsr not following interface");
    a_ior_dsr_bit: assert property (@(posedge clk_sys) disable iff (rst)
        dsrAccept |=> interfaceOptionReg[DSV_IOR_DSR_BIT] == $past(cmdArgPresent && cmdArg[0]))
        else $error("option bit wrong");
    a_test_stop: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h0) |=> testState == DSV_T_IDLE && !testOptionReg[DSV_TOR_RUN_BIT])
        else $error("test not stopped");
    a_local_start: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h1) or s_testCmd(4'h2) |=> testState == DSV_T_LOC)
        else $error("local loopback not started");
    a_ldata_start: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h3) |=> testState == DSV_T_LDATA) else $error("data loopback missing");
    a_remote_allow: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h4) |=> remoteLbAllow) else $error("remote not allowed");
    a_remote_deny: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h5) |=> !remoteLbAllow && testOptionReg[DSV_TOR_DENY_BIT])
        else $error("remote not denied");
    a_remote_start: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h6) |=> testState == DSV_T_REM) else $error("remote loopback missing");
    a_remote_self: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h7) |=> testState == DSV_T_REMST ##1 !dsrOut)
        else $error("remote self-test missing");
    a_local_self: assert property (@(posedge clk_sys) disable iff (rst)
        s_testCmd(4'h8) |=> testOptionReg[DSV_TOR_ST_BIT] && testOptionReg[DSV_TOR_LOC_BIT])
        else $error("local self-test missing");
    a_tor_mirror: assert property (@(posedge clk_sys) disable iff (rst)
        testOptionReg[DSV_TOR_RUN_BIT] == (testState != DSV_T_IDLE) && !testOptionReg[1])
        else $error("test option bits wrong");
    a_args_valid: assert property (@(posedge clk_sys) disable iff (rst)
        cmdValid && cmdCode == DSV_CMD_TEST && argOf(cmdArgPresent, cmdArg) <= 4'h8
        |=> cmdOk && !cmdError) else $error("valid test argument refused");
    a_timer_stop: assert property (@(posedge clk_sys) disable iff (rst)
        timerExpire && !testAccept |=> testState == DSV_T_IDLE)
        else $error("timer did not stop test");
    a_view_active: assert property (@(posedge clk_sys) disable iff (rst)
        viewAccept |=> viewValid && viewIndex == 4'h0 && viewData == $past(interfaceOptionReg))
        else $error("view did not open with active settings");
    a_view_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        cmdValid && cmdCode == DSV_CMD_VIEW && viewBusy |=> cmdError && !cmdOk)
        else $error("view accepted while streaming");
    a_view_hold: assert property (@(posedge clk_sys) disable iff (rst)
        viewValid && !viewReady |=> $stable(viewData) && $stable(viewIndex))
        else $error("view word changed while stalled");
    a_view_length: assert property (@(posedge clk_sys) disable iff (rst)
        viewValid && viewReady && viewIndex == DSV_VIEW_LAST |=> !viewValid)
        else $error("view ran past last word");
    a_view_profile: assert property (@(posedge clk_sys) disable iff (rst)
        viewBusy && viewReady && viewIndex == 4'h1 |=> viewData == $past(profIor[0]))
        else $error("profile word wrong");
    a_view_phone: assert property (@(posedge clk_sys) disable iff (rst)
        viewBusy && viewReady && viewIndex == 4'h8
        |=> viewIndex == DSV_VIEW_LAST && viewData == {3'h0, $past(phoneLen[3])})
        else $error("number slots skipped");
    a_bad_arg: assert property (@(posedge clk_sys) disable iff (rst)
        cmdBad && !timerExpire |=> cmdError && $stable(interfaceOptionReg) && $stable(testState))
        else $error("bad argument changed state");
endmodule
`default_nettype wire

// ### verification/dsv_terminal_model.sv
// Terminal-side sink for the configuration view report, with optional stalling
`timescale 1ns/100ps
`default_nettype none
module dsv_terminal_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Report stream
    input  wire logic       viewValid,
    input  wire logic [3:0] viewIndex,
    input  wire logic [7:0] viewData,
    output logic            viewReady,
    // Pace control
    input  wire logic       slow
);
    logic [7:0] words [16];
    int         wordCount;
    // Escape to command mode happens upstream; commands reach us already parsed
    // A slow terminal takes a word only every other cycle, to stress the hold of each word
    always_ff @(posedge clk_sys) begin
        if (rst)
            viewReady <= 1'b0;
        else
            viewReady <= slow ? ~viewReady : 1'b1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wordCount <= 0;
        end else if (viewValid && viewReady) begin
            words[viewIndex] <= viewData;
            wordCount <= wordCount + 1;
        end
    end
endmodule
`default_nettype wire

// ### verification/dsr_test_view_command_handler_bench.sv
// Self-checking bench for the option, test and view command handler
`timescale 1ns/100ps
`default_nettype none
module dsr_test_view_command_handler_bench;
    import dsv_pkg::*;
    typedef struct packed {
        logic [1:0] code;
        logic       pres;
        logic [3:0] arg;
        logic       err;
        logic [7:0] ior;
        logic [7:0] tor;
        logic [2:0] st;
    } dsv_row_t;
    localparam dsv_row_t ROWS [18] = '{
        '{2'h0, 1'b1, 4'h1, 1'b0, 8'h40, 8'h00, 3'h0}, '{2'h0, 1'b1, 4'h2, 1'b1, 8'h40, 8'h00, 3'h0},
        '{2'h0, 1'b0, 4'h1, 1'b0, 8'h00, 8'h00, 3'h0}, '{2'h0, 1'b1, 4'h1, 1'b0, 8'h40, 8'h00, 3'h0},
        '{2'h1, 1'b1, 4'h1, 1'b0, 8'h40, 8'h41, 3'h1}, '{2'h1, 1'b1, 4'h2, 1'b0, 8'h40, 8'h41, 3'h1},
        '{2'h1, 1'b1, 4'h3, 1'b0, 8'h40, 8'h44, 3'h3}, '{2'h1, 1'b1, 4'h9, 1'b1, 8'h40, 8'h44, 3'h3},
        '{2'h1, 1'b0, 4'h7, 1'b0, 8'h40, 8'h00, 3'h0}, '{2'h1, 1'b1, 4'h5, 1'b0, 8'h40, 8'h20, 3'h0},
        '{2'h1, 1'b1, 4'h4, 1'b0, 8'h40, 8'h00, 3'h0}, '{2'h1, 1'b1, 4'h6, 1'b0, 8'h40, 8'h48, 3'h2},
        '{2'h1, 1'b1, 4'h7, 1'b0, 8'h40, 8'h58, 3'h6}, '{2'h1, 1'b1, 4'h8, 1'b0, 8'h40, 8'h51, 3'h7},
        '{2'h1, 1'b1, 4'hF, 1'b1, 8'h40, 8'h51, 3'h7}, '{2'h2, 1'b1, 4'h0, 1'b1, 8'h40, 8'h51, 3'h7},
        '{2'h3, 1'b1, 4'h0, 1'b1, 8'h40, 8'h51, 3'h7}, '{2'h1, 1'b1, 4'h0, 1'b0, 8'h40, 8'h00, 3'h0}
    };
    logic clk_sys, rst, cmdValid, cmdArgPresent, cmdOk, cmdError, dsrStdLevel, dsrOut;
    logic remoteLbAllow, viewValid, viewReady, slow;
    dsv_cmd_t   cmdCode;
    dsv_test_t  testState;
    logic [3:0] cmdArg;
    logic [7:0] testTimer, interfaceOptionReg, testOptionReg, viewData;
    logic [7:0] profIor [2];
    logic [7:0] profTor [2];
    logic [4:0] phoneLen [4];
    logic [3:0] viewIndex;
    int         badCount, checks, i;
    dsv_command_handler #(.SECOND_CYCLES(4)) u_dsv_command_handler (.clk_sys(clk_sys), .rst(rst),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArgPresent(cmdArgPresent), .cmdArg(cmdArg),
        .cmdOk(cmdOk), .cmdError(cmdError), .dsrStdLevel(dsrStdLevel), .dsrOut(dsrOut),
        .testTimer(testTimer), .interfaceOptionReg(interfaceOptionReg),
        .testOptionReg(testOptionReg), .testState(testState), .remoteLbAllow(remoteLbAllow),
        .profIor(profIor), .profTor(profTor), .phoneLen(phoneLen), .viewValid(viewValid),
        .viewReady(viewReady), .viewIndex(viewIndex), .viewData(viewData));
    dsv_terminal_model u_dsv_terminal_model (.clk_sys(clk_sys), .rst(rst), .viewValid(viewValid),
        .viewIndex(viewIndex), .viewData(viewData), .viewReady(viewReady), .slow(slow));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            badCount++;
        end
    endtask
    // Strobe for one cycle; the answer is looked at in the cycle after the taking edge
    task automatic cmd(input logic [1:0] code, input logic pres, input logic [3:0] arg,
                       input logic err);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCode <= dsv_cmd_t'(code);
        cmdArgPresent <= pres;
        cmdArg <= arg;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        #1;
        chk("cmdOk", {7'h0, ~err}, {7'h0, cmdOk});
        chk("cmdError", {7'h0, err}, {7'h0, cmdError});
    endtask
    task automatic doReset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("dsrOut", 8'h01, {7'h0, dsrOut});
        chk("interfaceOptionReg", DSV_IOR_RESET, interfaceOptionReg);
        chk("testOptionReg", DSV_TOR_RESET, testOptionReg);
        chk("testState", 8'h00, {5'h0, testState});
        chk("remoteLbAllow", 8'h01, {7'h0, remoteLbAllow});
        $display("reset test done");
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        badCount++;
        conclude();
    end
    initial begin
        {rst, cmdValid, cmdArgPresent, cmdArg, slow, testTimer} = '0;
        cmdCode = DSV_CMD_DSR;
        dsrStdLevel = 1'b1;
        profIor = '{8'h11, 8'h22};
        profTor = '{8'h33, 8'h44};
        phoneLen = '{5'h01, 5'h07, 5'h0C, 5'h19};
        doReset();
        // Standard level held high, so only self-test may pull data-set-ready off
        for (i = 0; i < 18; i++) begin
            cmd(ROWS[i].code, ROWS[i].pres, ROWS[i].arg, ROWS[i].err);
            chk("interfaceOptionReg", ROWS[i].ior, interfaceOptionReg);
            chk("testOptionReg", ROWS[i].tor, testOptionReg);
            chk("testState", {5'h0, ROWS[i].st}, {5'h0, testState});
            chk("remoteLbAllow", {7'h0, ~ROWS[i].tor[5]}, {7'h0, remoteLbAllow});
            @(posedge clk_sys);
            #1;
            chk("dsrOut", {7'h0, ROWS[i].st[2:1] != 2'h3}, {7'h0, dsrOut});
        end
        $display("table test done");
        @(posedge clk_sys);
        dsrStdLevel <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("dsrOut", 8'h00, {7'h0, dsrOut});
        cmd(2'h0, 1'b1, 4'h0, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("dsrOut", 8'h01, {7'h0, dsrOut});
        $display("data-set-ready level test done");
        // Two seconds of four cycles each: local and remote tests both end
        @(posedge clk_sys);
        testTimer <= 8'h02;
        cmd(2'h1, 1'b1, 4'h1, 1'b0);
        repeat (5) @(posedge clk_sys);
        #1;
        chk("testState", 8'h01, {5'h0, testState});
        repeat (6) @(posedge clk_sys);
        #1;
        chk("testState", 8'h00, {5'h0, testState});
        cmd(2'h1, 1'b1, 4'h6, 1'b0);
        repeat (5) @(posedge clk_sys);
        #1;
        chk("testState", 8'h02, {5'h0, testState});
        repeat (6) @(posedge clk_sys);
        #1;
        chk("testState", 8'h00, {5'h0, testState});
        @(posedge clk_sys);
        testTimer <= 8'h00;
        cmd(2'h1, 1'b1, 4'h5, 1'b0);
        $display("timer test done");
        @(posedge clk_sys);
        slow <= 1'b1;
        cmd(2'h2, 1'b0, 4'h0, 1'b0);
        cmd(2'h2, 1'b0, 4'h0, 1'b1);
        i = 0;
        while (viewValid === 1'b1 && i < 100) begin
            @(posedge clk_sys);
            i++;
        end
        #1;
        chk("wordCount", 8'h0A, u_dsv_terminal_model.wordCount[7:0]);
        chk("word0", 8'h00, u_dsv_terminal_model.words[0]);
        chk("word1", 8'h20, u_dsv_terminal_model.words[1]);
        for (i = 0; i < 2; i++) begin
            chk("profileIor", profIor[i], u_dsv_terminal_model.words[2 * i + 2]);
            chk("profileTor", profTor[i], u_dsv_terminal_model.words[2 * i + 3]);
        end
        for (i = 0; i < 4; i++) begin
            chk("phoneWord", {3'h0, phoneLen[i]}, u_dsv_terminal_model.words[i + 6]);
        end
        $display("view test done");
        cmd(2'h1, 1'b1, 4'h8, 1'b0);
        doReset();
        conclude();
    end
endmodule
`default_nettype wire
